// file: spmp_pkg.sv
// package: register map, field positions and timing of the serial port
package spmp_pkg;
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_DATA = 2'h2;
    localparam logic [1:0] ADDR_PINS = 2'h3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int CTL_IRQ_EN = 7;
    localparam int CTL_ENABLE = 6;
    localparam int CTL_LSB_FIRST = 5;
    localparam int CTL_MASTER = 4;
    localparam int CTL_POLARITY = 3;
    localparam int CTL_PHASE = 2;
    localparam int STA_DONE = 7;
    localparam int STA_COLLISION = 6;
    localparam int STA_DOUBLE = 0;
    localparam int PIN_SS_OUT_EN = 0;
    localparam int PIN_SS_OUT_VAL = 1;
    localparam int PIN_MISO_OUT_EN = 2;
    localparam int PIN_MOSI_OUT_EN = 3;
    localparam int PIN_SCK_OUT_EN = 4;
    localparam logic [7:0] PINS_RESET = 8'h00;
    localparam int BITS_PER_BYTE = 8;
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    // half sck period in system clocks, indexed by {double, rate}
    localparam logic [6:0] HALF_DIV_0 = 7'h02;
    localparam logic [6:0] HALF_DIV_1 = 7'h08;
    localparam logic [6:0] HALF_DIV_2 = 7'h20;
    localparam logic [6:0] HALF_DIV_3 = 7'h40;
    localparam logic [6:0] HALF_DIV_4 = 7'h01;
    localparam logic [6:0] HALF_DIV_5 = 7'h04;
    localparam logic [6:0] HALF_DIV_6 = 7'h10;
    localparam logic [6:0] HALF_DIV_7 = 7'h20;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spmp_bus_s;
endpackage

// file: spmp_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/100ps
module spmp_sync
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // level
    input wire logic i_d,
    output logic o_q
);
    logic meta;
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta <= 1'b0;
            o_q <= 1'b0;
        end
        else
        begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

// file: spmp_divider.sv
// sck half-period tick generator for master role
`timescale 1ns/100ps
module spmp_divider
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic [6:0] i_half,
    output logic o_tick
);
    logic [6:0] count;
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            count <= 7'h00;
            o_tick <= 1'b0;
        end
        else if (!i_run)
        begin
            count <= 7'h00;
            o_tick <= 1'b0;
        end
        else if (count + 7'h01 >= i_half)
        begin
            count <= 7'h00;
            o_tick <= 1'b1;
        end
        else
        begin
            count <= count + 7'h01;
            o_tick <= 1'b0;
        end
    end
endmodule

// file: spmp_port.sv
// serial port top: registers, master clock, shift logic, pin control
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
module spmp_port
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // register port
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // cpu side
    input wire logic I_GLOBAL_IRQ_EN,
    input wire logic I_IRQ_ACK,
    output logic O_IRQ,
    // serial pins
    input wire logic I_SCK,
    output logic O_SCK,
    output logic O_SCK_OE,
    input wire logic I_MOSI,
    output logic O_MOSI,
    output logic O_MOSI_OE,
    input wire logic I_MISO,
    output logic O_MISO,
    output logic O_MISO_OE,
    input wire logic I_SS_N,
    output logic O_SS_N,
    output logic O_SS_N_OE
);
    spmp_pkg::spmp_bus_s bus;
    logic [7:0] control;
    logic [7:0] pins;
    logic done_flag;
    logic coll_flag;
    logic double_speed;
    logic status_seen;
    logic [7:0] shifter;
    logic [7:0] rx_buf;
    logic [3:0] bit_cnt;
    logic sck_lvl;
    logic busy;
    logic sck_s, ss_s, mosi_s, miso_s;
    logic sck_prev;
    logic tick;
    logic out_bit;
    logic [6:0] half;
    logic enabled, master, ss_in_mode, demote;
    logic data_access, data_write, status_read;
    logic s_sel, s_lead, s_trail, m_lead, m_trail;
    logic sample_ev, setup_ev, first_ev, in_bit, byte_end;
    logic in_hold;
    logic tail;
    logic [2:0] m_cap;
    logic [7:0] m_rx;
    logic [3:0] m_got;
    logic m_end;

    assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign enabled = control[spmp_pkg::CTL_ENABLE];
    assign master = control[spmp_pkg::CTL_MASTER];
    assign ss_in_mode = !pins[spmp_pkg::PIN_SS_OUT_EN];
    assign data_access = (bus.wr || bus.rd) && bus.addr == spmp_pkg::ADDR_DATA;
    assign data_write = bus.wr && bus.addr == spmp_pkg::ADDR_DATA;
    assign status_read = bus.rd && bus.addr == spmp_pkg::ADDR_STATUS;
    // a low SS as input in master role means another master took the bus
    assign demote = enabled && master && ss_in_mode && !ss_s;

    // pins from outside pass two flops before use
    spmp_sync u_sync_sck (.i_clk(I_CLK), .i_reset(I_RESET), .i_d(I_SCK),
        .o_q(sck_s));
    spmp_sync u_sync_ss (.i_clk(I_CLK), .i_reset(I_RESET), .i_d(I_SS_N),
        .o_q(ss_s));
    spmp_sync u_sync_mosi (.i_clk(I_CLK), .i_reset(I_RESET), .i_d(I_MOSI),
        .o_q(mosi_s));
    spmp_sync u_sync_miso (.i_clk(I_CLK), .i_reset(I_RESET), .i_d(I_MISO),
        .o_q(miso_s));

    always_comb
    begin
        case ({double_speed, control[1:0]})
            3'h0: half = spmp_pkg::HALF_DIV_0;
            3'h1: half = spmp_pkg::HALF_DIV_1;
            3'h2: half = spmp_pkg::HALF_DIV_2;
            3'h3: half = spmp_pkg::HALF_DIV_3;
            3'h4: half = spmp_pkg::HALF_DIV_4;
            3'h5: half = spmp_pkg::HALF_DIV_5;
            3'h6: half = spmp_pkg::HALF_DIV_6;
            default: half = spmp_pkg::HALF_DIV_7;
        endcase
    end

    spmp_divider u_div (.i_clk(I_CLK), .i_reset(I_RESET),
        .i_run(busy && master && enabled), .i_half(half), .o_tick(tick));

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            sck_prev <= 1'b0;
        else
            sck_prev <= sck_s;
    end

    // slave edges, relative to idle level; only while selected
    assign s_sel = enabled && !master && !ss_s;
    assign s_lead = s_sel && (sck_s != sck_prev)
        && (sck_prev == control[spmp_pkg::CTL_POLARITY]);
    assign s_trail = s_sel && (sck_s != sck_prev)
        && (sck_prev != control[spmp_pkg::CTL_POLARITY]);
    // master edges: a tick flips sck; leading when sck sits at idle
    assign m_lead = busy && master && enabled && tick && !sck_lvl;
    assign m_trail = busy && master && enabled && tick && sck_lvl;
    assign sample_ev = control[spmp_pkg::CTL_PHASE] ?
        (s_trail || m_trail) : (s_lead || m_lead);
    assign setup_ev = control[spmp_pkg::CTL_PHASE] ?
        (s_lead || m_lead) : (s_trail || m_trail);
    assign in_bit = master ? miso_s : mosi_s;
    assign byte_end = sample_ev && bit_cnt == 4'(spmp_pkg::BITS_PER_BYTE - 1);
    assign out_bit = control[spmp_pkg::CTL_LSB_FIRST] ?
        shifter[0] : shifter[7];
    // phase one: first leading edge only sets up the already presented bit
    assign first_ev = bit_cnt == 4'h0 && control[spmp_pkg::CTL_PHASE];
    assign m_end = m_cap[2] && m_got == 4'(spmp_pkg::BITS_PER_BYTE - 1);

    // master input comes back through our sck flop and the pin
    // synchroniser, so each sample is taken three clocks after its tick
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            m_cap <= 3'h0;
            m_rx <= 8'h00;
            m_got <= 4'h0;
        end
        else if (!enabled || !master || demote)
        begin
            m_cap <= 3'h0;
            m_got <= 4'h0;
        end
        else
        begin
            m_cap <= {m_cap[1:0], sample_ev};
            if (m_cap[2])
            begin
                m_rx <= control[spmp_pkg::CTL_LSB_FIRST] ?
                    {miso_s, m_rx[7:1]} : {m_rx[6:0], miso_s};
                m_got <= m_end ? 4'h0 : m_got + 4'h1;
            end
        end
    end

    // control register, master select cleared by demotion
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            control <= spmp_pkg::CONTROL_RESET;
        else if (bus.wr && bus.addr == spmp_pkg::ADDR_CONTROL)
            control <= bus.wdata;
        else if (demote)
            control[spmp_pkg::CTL_MASTER] <= 1'b0;
    end

    // pin direction register: SS as output is a plain gpio, enabled in master role only
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            pins <= spmp_pkg::PINS_RESET;
        else if (bus.wr && bus.addr == spmp_pkg::ADDR_PINS)
            pins <= bus.wdata;
    end

    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            double_speed <= 1'b0;
        else if (bus.wr && bus.addr == spmp_pkg::ADDR_STATUS)
            double_speed <= bus.wdata[spmp_pkg::STA_DOUBLE];
    end

    // shift engine
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            shifter <= 8'h00;
            bit_cnt <= 4'h0;
            busy <= 1'b0;
            sck_lvl <= 1'b0;
            rx_buf <= 8'h00;
            in_hold <= 1'b0;
            tail <= 1'b0;
        end
        else if (!enabled || demote || (!master && ss_s))
        begin
            // deselect drops any partial byte at once
            bit_cnt <= 4'h0;
            tail <= 1'b0;
            busy <= 1'b0;
            sck_lvl <= 1'b0;
            if (data_write)
                shifter <= bus.wdata;
        end
        else
        begin
            if (data_write && !busy)
            begin
                shifter <= bus.wdata;
                busy <= master;
            end
            if (tick && busy && master)
                sck_lvl <= !sck_lvl;
            if (s_lead || s_trail)
                busy <= 1'b1;
            // sampled bit is held aside so the output pin stays still
            if (setup_ev && !first_ev)
                shifter <= control[spmp_pkg::CTL_LSB_FIRST] ?
                    {in_hold, shifter[7:1]} : {shifter[6:0], in_hold};
            if (sample_ev)
            begin
                in_hold <= in_bit;
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_end)
            begin
                bit_cnt <= 4'h0;
                if (!master)
                    rx_buf <= control[spmp_pkg::CTL_LSB_FIRST] ?
                        {in_bit, shifter[7:1]} : {shifter[6:0], in_bit};
                // master in phase zero still owes the closing edge
                if (master && !control[spmp_pkg::CTL_PHASE])
                    tail <= 1'b1;
                else
                    busy <= 1'b0;
            end
            if (m_trail && tail)
            begin
                busy <= 1'b0;
                tail <= 1'b0;
            end
            if (m_end)
                rx_buf <= control[spmp_pkg::CTL_LSB_FIRST] ?
                    {miso_s, m_rx[7:1]} : {m_rx[6:0], miso_s};
        end
    end

    // flags: hardware set wins over any clear in the same cycle
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            done_flag <= 1'b0;
            coll_flag <= 1'b0;
            status_seen <= 1'b0;
        end
        else
        begin
            if (status_read)
                status_seen <= done_flag || coll_flag;
            else if (data_access)
                status_seen <= 1'b0;
            if ((byte_end && !master) || m_end || demote)
                done_flag <= 1'b1;
            else if (I_IRQ_ACK || (data_access && status_seen))
                done_flag <= 1'b0;
            if (data_write && busy)
                coll_flag <= 1'b1;
            else if (data_access && status_seen)
                coll_flag <= 1'b0;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            O_RDATA <= 8'h00;
        else if (bus.rd)
            case (bus.addr)
                spmp_pkg::ADDR_CONTROL: O_RDATA <= control;
                spmp_pkg::ADDR_STATUS: O_RDATA <= {done_flag, coll_flag,
                    5'h00, double_speed};
                spmp_pkg::ADDR_DATA: O_RDATA <= rx_buf;
                spmp_pkg::ADDR_PINS: O_RDATA <= pins;
                default: O_RDATA <= 8'h00;
            endcase
        else
            O_RDATA <= 8'h00;
    end

    // pin drivers
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            O_IRQ <= 1'b0;
            O_SCK <= 1'b0;
            O_SCK_OE <= 1'b0;
            O_MOSI <= 1'b0;
            O_MOSI_OE <= 1'b0;
            O_MISO <= 1'b0;
            O_MISO_OE <= 1'b0;
            O_SS_N <= 1'b1;
            O_SS_N_OE <= 1'b0;
        end
        else
        begin
            O_IRQ <= control[spmp_pkg::CTL_IRQ_EN] && done_flag
                && I_GLOBAL_IRQ_EN;
            O_SCK <= sck_lvl ^ control[spmp_pkg::CTL_POLARITY];
            O_SCK_OE <= enabled && master && !demote
                && pins[spmp_pkg::PIN_SCK_OUT_EN];
            O_MOSI <= out_bit;
            O_MOSI_OE <= enabled && master && !demote
                && pins[spmp_pkg::PIN_MOSI_OUT_EN];
            O_MISO <= out_bit;
            O_MISO_OE <= s_sel && pins[spmp_pkg::PIN_MISO_OUT_EN];
            O_SS_N <= pins[spmp_pkg::PIN_SS_OUT_VAL];
            O_SS_N_OE <= master && pins[spmp_pkg::PIN_SS_OUT_EN];
        end
    end

    chk_demote_clears: assert property (@(posedge I_CLK) disable iff (I_RESET)
        demote && !(bus.wr && bus.addr == spmp_pkg::ADDR_CONTROL)
        |=> !control[spmp_pkg::CTL_MASTER] && done_flag)
        else $error("demotion did not clear master");
    chk_done_sets: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (byte_end && !master) || m_end |=> done_flag)
        else $error("done flag not set");
    chk_coll_sets: assert property (@(posedge I_CLK) disable iff (I_RESET)
        data_write && busy |=> coll_flag)
        else $error("collision not flagged");
    chk_irq_gate: assert property (@(posedge I_CLK) disable iff (I_RESET)
        O_IRQ |-> $past(done_flag) && $past(I_GLOBAL_IRQ_EN))
        else $error("irq without cause");
    chk_status_zero: assert property (@(posedge I_CLK) disable iff (I_RESET)
        $past(status_read) |-> O_RDATA[5:1] == 5'h00)
        else $error("reserved status bits nonzero");
    chk_miso_off: assert property (@(posedge I_CLK) disable iff (I_RESET)
        ss_s ##1 ss_s |-> !O_MISO_OE)
        else $error("miso driven while deselected");
    chk_idle_off: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !enabled |=> bit_cnt == 4'h0 && !busy)
        else $error("shift active while disabled");
    chk_master_end: assert property (@(posedge I_CLK) disable iff (I_RESET)
        master && ((tail && m_trail)
        || (busy && byte_end && control[spmp_pkg::CTL_PHASE]))
        |=> !busy)
        else $error("master clock not stopped");
endmodule

// file: spmp_peer.sv
// far-side serial partner: answers as slave, or drives the port as master
`timescale 1ns/100ps
module spmp_peer
#(
    parameter int HALF = 160
)
(
    // transfer mode
    input wire logic i_clock_idle_polarity,
    input wire logic i_clock_sample_phase,
    input wire logic i_lsb,
    // pin levels
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_miso,
    input wire logic i_ss_n,
    // pin drive
    output logic o_sck,
    output logic o_mosi,
    output logic o_miso,
    output logic o_ss_n
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic slave_on = 1'b0;
    logic m_run = 1'b0;
    logic m_sck = 1'b0;
    int n = 0;

    initial
    begin
        o_mosi = 1'b0;
        o_miso = 1'b0;
        o_ss_n = 1'b1;
    end

    // clock stands at its idle level outside frames
    assign o_sck = m_run ? m_sck : i_clock_idle_polarity;

    function automatic logic pick(input logic [7:0] b, input int k);
        return i_lsb ? b[k] : b[7 - k];
    endfunction

    function automatic logic [7:0] sh(input logic [7:0] r, input logic b);
        return i_lsb ? {b, r[7:1]} : {r[6:0], b};
    endfunction

    // released line shows the inverse of its last value
    always @(i_ss_n)
    begin
        n = 0;
        if (!i_ss_n && slave_on && !i_clock_sample_phase)
            o_miso = pick(tx, 0);
        else
            o_miso = ~o_miso;
    end

    always @(i_sck)
    begin
        if (!i_ss_n && slave_on)
        begin
            if ((i_sck != i_clock_idle_polarity) ^ i_clock_sample_phase)
            begin
                rx = sh(rx, i_mosi);
                n++;
            end
            else if (n < 8)
                o_miso = pick(tx, n);
        end
    end

    // half period of eight clocks keeps sck well below clock over four
    task automatic xfer(input logic [7:0] t, input int bits,
                        output logic [7:0] r);
        r = 8'h00;
        #3 o_ss_n = 1'b0;
        if (!i_clock_sample_phase)
            o_mosi = pick(t, 0);
        #(2 * HALF);
        m_sck = i_clock_idle_polarity;
        m_run = 1'b1;
        for (int i = 0; i < bits; i++)
        begin
            m_sck = ~i_clock_idle_polarity;
            if (i_clock_sample_phase)
                o_mosi = pick(t, i);
            else
                r = sh(r, i_miso);
            #(HALF);
            m_sck = i_clock_idle_polarity;
            if (i_clock_sample_phase)
                r = sh(r, i_miso);
            else if (i < 7)
                o_mosi = pick(t, i + 1);
            #(HALF);
        end
        m_run = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = ~o_mosi;
    endtask
endmodule

// file: spmp_port_tb_top.sv
// self-checking bench: registers, master and slave transfers, mode fault
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, e, g)
module spmp_port_tb_top;
    localparam logic [1:0] A_CTL = spmp_pkg::ADDR_CONTROL;
    localparam logic [1:0] A_STA = spmp_pkg::ADDR_STATUS;
    localparam logic [1:0] A_DAT = spmp_pkg::ADDR_DATA;
    localparam logic [1:0] A_PIN = spmp_pkg::ADDR_PINS;
    logic clk = 1'b0;
    logic rst = 1'b1;
    spmp_pkg::spmp_bus_s bus = '0;
    logic glob = 1'b0;
    logic ack = 1'b0;
    logic clock_idle_polarity = 1'b0;
    logic clock_sample_phase = 1'b0;
    logic lsb = 1'b0;
    logic [7:0] rdata;
    logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
    logic p_sck, p_mosi, p_miso, p_ss;
    logic sck_q = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;
    int gap = 0;
    int half_seen = 0;
    int edges = 0;
    wire sck_w = sck_oe ? sck_o : p_sck;
    wire mosi_w = mosi_oe ? mosi_o : p_mosi;
    wire miso_w = miso_oe ? miso_o : p_miso;
    wire ss_w = ss_oe ? ss_o : p_ss;

    always #(spmp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

    spmp_port u_dut (.I_CLK(clk), .I_RESET(rst), .I_ADDR(bus.addr),
        .I_WDATA(bus.wdata), .I_WR(bus.wr), .I_RD(bus.rd), .O_RDATA(rdata),
        .I_GLOBAL_IRQ_EN(glob), .I_IRQ_ACK(ack), .O_IRQ(irq),
        .I_SCK(sck_w), .O_SCK(sck_o), .O_SCK_OE(sck_oe), .I_MOSI(mosi_w),
        .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe), .I_MISO(miso_w),
        .O_MISO(miso_o), .O_MISO_OE(miso_oe), .I_SS_N(ss_w),
        .O_SS_N(ss_o), .O_SS_N_OE(ss_oe));

    spmp_peer u_peer (.i_clock_idle_polarity(clock_idle_polarity), .i_clock_sample_phase(clock_sample_phase), .i_lsb(lsb),
        .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .i_ss_n(ss_w),
        .o_sck(p_sck), .o_mosi(p_mosi), .o_miso(p_miso), .o_ss_n(p_ss));

    // length of the last sck half period and count of its edges
    always @(posedge clk)
    begin
        sck_q <= sck_o;
        gap <= (sck_o != sck_q) ? 1 : gap + 1;
        if (sck_o != sck_q)
        begin
            half_seen <= gap;
            edges <= edges + 1;
        end
    end

    function automatic logic [7:0] half_of(input logic d, input logic [1:0] r);
        logic [7:0] dv;
        dv = 8'h04 << ((r == 2'h3) ? 5 : 2 * r);
        return d ? dv >> 2 : dv >> 1;
    endfunction

    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string n, input logic [7:0] e,
                         input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic pause(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rdc(input string n, input logic [1:0] a,
                       input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check(n, e, v);
    endtask

    task automatic wait_done(output logic [7:0] s);
        for (int k = 0; k < 1000; k++)
        begin
            rd(A_STA, s);
            if (s[7] === 1'b1)
                return;
        end
        num_errors++;
        print_verdict();
    endtask

    initial
    begin
        logic [7:0] v;
        logic [7:0] t;
        logic [7:0] pt;
        logic ien;
        logic dbl;
        logic [1:0] rate;
        void'($urandom(32'hC1A0));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc("control", A_CTL, spmp_pkg::CONTROL_RESET);
        rdc("pins", A_PIN, spmp_pkg::PINS_RESET);
        wr(A_STA, 8'hFF);
        rdc("status", A_STA, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            {clock_idle_polarity, clock_sample_phase} = i[1:0];
            dbl = i[2];
            rate = 2'($urandom);
            lsb = 1'($urandom);
            ien = 1'($urandom);
            glob <= 1'($urandom);
            t = 8'($urandom);
            u_peer.tx = 8'($urandom);
            u_peer.slave_on = 1'b1;
            wr(A_CTL, {ien, 1'b1, lsb, 1'b1, clock_idle_polarity, clock_sample_phase, rate});
            wr(A_STA, {7'h00, dbl});
            wr(A_PIN, 8'h19);
            pause(2);
            `CHK("sck idle", clock_idle_polarity, sck_o);
            `CHK("ss pin", 1'b0, ss_o);
            edges = 0;
            wr(A_DAT, t);
            if (i == 5)
                wr(A_DAT, ~t);
            wait_done(v);
            pause(2 * half_of(dbl, rate) + 4);
            `CHK("status", {1'b1, i == 5, 5'h00, dbl}, v);
            `CHK("irq", ien & glob, irq);
            `CHK("peer rx", t, u_peer.rx);
            `CHK("edges", 8'h10, 8'(edges));
            `CHK("half", half_of(dbl, rate), 8'(half_seen));
            if (i[0])
            begin
                @(posedge clk) ack <= 1'b1;
                @(posedge clk) ack <= 1'b0;
                rdc("status", A_STA, {1'b0, i == 5, 5'h00, dbl});
            end
            rdc("data", A_DAT, u_peer.tx);
            rdc("status", A_STA, {7'h00, dbl});
            wr(A_PIN, 8'h1B);
            pause(2);
            `CHK("ss pin", 1'b1, ss_o);
        end
        u_peer.slave_on = 1'b0;
        wr(A_STA, 8'h00);
        wr(A_CTL, 8'hD0);
        wr(A_PIN, 8'h18);
        glob <= 1'b1;
        u_peer.o_ss_n = 1'b0;
        pause(8);
        `CHK("demoted", 1'b0, sck_oe | mosi_oe);
        `CHK("irq", 1'b1, irq);
        rdc("control", A_CTL, 8'hC0);
        rdc("status", A_STA, 8'h80);
        rd(A_DAT, v);
        u_peer.o_ss_n = 1'b1;
        wr(A_CTL, 8'hD0);
        rdc("control", A_CTL, 8'hD0);
        wr(A_PIN, 8'h04);
        for (int i = 0; i < 4; i++)
        begin
            {clock_idle_polarity, clock_sample_phase} = i[1:0];
            lsb = 1'($urandom);
            t = 8'($urandom);
            pt = 8'($urandom);
            wr(A_CTL, {2'h1, lsb, 1'b0, clock_idle_polarity, clock_sample_phase, 2'h3});
            pause(2);
            `CHK("miso off", 1'b0, miso_oe);
            if (i == 0)
            begin
                wr(A_DAT, ~t);
                u_peer.xfer(8'hA5, 3, v);
                rdc("status", A_STA, 8'h00);
            end
            wr(A_DAT, t);
            u_peer.xfer(pt, 8, v);
            `CHK("peer rx", t, v);
            wait_done(v);
            rdc("data", A_DAT, pt);
        end
        wr(A_CTL, 8'h10);
        wr(A_PIN, 8'h19);
        pause(2);
        edges = 0;
        wr(A_DAT, 8'h5A);
        pause(64);
        `CHK("edges off", 8'h00, 8'(edges));
        rdc("status", A_STA, 8'h00);
        print_verdict();
    end
endmodule
